// ### pkg/rcp_pkg.sv
// package: register map, timing constants and types of the ranging command block
package rcp_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned LEAD_STEP_US = 100;
  localparam int unsigned LEAD_STEP_CYC = LEAD_STEP_US * CLK_MHZ;
  localparam int unsigned PERIOD_UNIT_MS = 1;
  localparam int unsigned PERIOD_UNIT_CYC = PERIOD_UNIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned RANGE_US = 1000;
  localparam int unsigned RANGE_CYC = RANGE_US * CLK_MHZ;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_PARAM_LO = 8'h00;
  localparam logic [7:0] OFF_PARAM_HI = 8'h04;
  localparam logic [7:0] OFF_COMMAND = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h1C;
  localparam logic [7:0] OFF_STATE = 8'h20;
  // ---------------------------------------------------------------
  // codes and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_COMBINED = 8'h02;
  localparam logic [7:0] CMD_DISTANCE = 8'h03;
  localparam logic [7:0] CMD_STOP = 8'hFF;
  localparam logic [7:0] RSV_FILL = 8'hFF;
  localparam logic [7:0] RSV_ZERO = 8'h00;
  localparam logic [3:0] PIN_IN_LOW = 4'h1;
  localparam logic [3:0] PIN_IN_HIGH = 4'h2;
  localparam logic [3:0] PIN_PULSE = 4'h3;
  localparam logic [3:0] PIN_DRV_LOW = 4'h4;
  localparam logic [3:0] PIN_DRV_HIGH = 4'h5;
  localparam logic [7:0] PIN_FN_RST = 8'h44;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam int unsigned ALG_PROX_BIT = 0;
  localparam int unsigned ALG_DIST_BIT = 1;
  localparam int unsigned STS_W = 2;
  localparam int unsigned STS_DONE = 0;
  localparam int unsigned STS_PARAM = 1;
  localparam int unsigned STATE_BUSY_BIT = 8;
  localparam int unsigned STATE_PROX_BIT = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] param_byte_three;
    logic [7:0] repeat_period_byte;
    logic [7:0] param_byte_one;
    logic [7:0] param_byte_zero;
  } rcp_param_lo_t;
  typedef struct packed {
    logic [7:0] algorithm_select_byte;
    logic [7:0] pin_function_byte;
    logic [7:0] pulse_timing_byte;
  } rcp_param_hi_t;
  typedef struct packed {
    logic [7:0] pulse_code;
    logic [7:0] period_ms;
    logic prox;
    logic second_force;
  } rcp_run_cfg_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_EMIT = 3'b010,
    ST_DONE = 3'b011,
    ST_WAIT = 3'b100,
    ST_ARM = 3'b101
  } rcp_state_t;
endpackage : rcp_pkg

// ### hw/rcp_top.sv
// ranging command block: axi4-lite registers, measurement sequencer, pin framing
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - pulse code 0 no frame, 1 no lead, 2 lead 100us, 3 lead 200us
// - framing pin falls on the same edge the emitter stops
// - pulse code acts only on pins set to pulse output, and on the second pin in distance-only runs
// - repeat period byte in ms; zero means one single measurement
// - period shorter than ranging time: measurements run back to back
// - measurement done raises interrupt only when its enable is set
// - measurement done advances the transaction identifier
// - distance-only command uses five bytes and no proximity algorithm
// - pin-function field value 3 selects emitter pulse output
// - algorithm-select bit 0 enables the proximity algorithm
module rcp_top import rcp_pkg::*; #(
  parameter int unsigned LEAD_STEP_CYCLES = LEAD_STEP_CYC,
  parameter int unsigned PERIOD_CYCLES = PERIOD_UNIT_CYC,
  parameter int unsigned RANGE_CYCLES = RANGE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic aux_pin_first_i,
  output logic aux_pin_first_o,
  output logic aux_pin_first_oe,
  input wire logic aux_pin_second_i,
  output logic aux_pin_second_o,
  output logic aux_pin_second_oe,
  output logic emitter_on,
  output logic irq
);
  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : is_reg

  function automatic logic is_mapped(input logic [7:0] a);
    return is_reg(a, OFF_PARAM_LO) || is_reg(a, OFF_PARAM_HI) || is_reg(a, OFF_COMMAND) ||
           is_reg(a, OFF_IRQ_STATUS) || is_reg(a, OFF_IRQ_CLEAR) ||
           is_reg(a, OFF_IRQ_ENABLE) || is_reg(a, OFF_STATE);
  endfunction : is_mapped

  // {oe, out} for one aux pin
  function automatic logic [1:0] pin_drive(input logic [3:0] fn, input logic pulse,
                                           input logic frame);
    if (pulse) begin
      return {1'b1, frame};
    end
    case (fn)
      PIN_PULSE: return 2'b10;
      PIN_DRV_LOW: return 2'b10;
      PIN_DRV_HIGH: return 2'b11;
      default: return 2'b00;
    endcase
  endfunction : pin_drive

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  rcp_state_t state_q, state_d;
  rcp_param_lo_t plo_q;
  rcp_param_hi_t phi_q;
  rcp_run_cfg_t run_q;
  logic [7:0] cmd_q, tid_q, aw_addr_q, ar_addr;
  logic [31:0] w_data_q, rd_mux, cnt_q, per_q, lead_cyc, lead_need, period_cyc, frame_cnt_q;
  logic [3:0] w_strb_q, fn_first, fn_second;
  logic [STS_W-1:0] sts_q, sts_d, en_q, sts_set, sts_clr;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q, drv_first, drv_second;
  logic [31:0] rdata_q;
  logic emitter_on_q, irq_q, frame_q, first_o_q, first_oe_q, second_o_q, second_oe_q;
  logic do_wr, cmd_wr, go_comb, go_dist, stop, inhibit, pulse_first, pulse_second;
  logic active_q, active_d, frame_d, restart;

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  assign do_wr = !awready_q && !wready_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_wr) begin
        awready_q <= 1'b1;
      end
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_wr) begin
        wready_q <= 1'b1;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // parameter, command and enable registers
  // ---------------------------------------------------------------
  assign cmd_wr = do_wr && is_reg(aw_addr_q, OFF_COMMAND) && w_strb_q[0];
  assign go_comb = cmd_wr && w_data_q[7:0] == CMD_COMBINED;
  assign go_dist = cmd_wr && w_data_q[7:0] == CMD_DISTANCE;
  assign stop = cmd_wr && w_data_q[7:0] == CMD_STOP;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      plo_q <= '0;
      phi_q <= '{algorithm_select_byte: 8'h00, pin_function_byte: PIN_FN_RST,
                 pulse_timing_byte: 8'h00};
      cmd_q <= CMD_RST;
      en_q <= '0;
    end else if (do_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb_q[i] && is_reg(aw_addr_q, OFF_PARAM_LO)) begin
          plo_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
        end
      end
      // params hi holds three bytes only
      for (int j = 0; j < 3; j++) begin
        if (w_strb_q[j] && is_reg(aw_addr_q, OFF_PARAM_HI)) begin
          phi_q[j*8 +: 8] <= w_data_q[j*8 +: 8];
        end
      end
      if (cmd_wr) begin
        cmd_q <= w_data_q[7:0];
      end
      if (is_reg(aw_addr_q, OFF_IRQ_ENABLE) && w_strb_q[0]) begin
        en_q <= w_data_q[STS_W-1:0];
      end
    end
  end

  // settings frozen for the run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= '0;
    end else if (go_comb || go_dist) begin
      run_q.pulse_code <= phi_q.pulse_timing_byte;
      run_q.period_ms <= plo_q.repeat_period_byte;
      run_q.prox <= go_comb && (phi_q.algorithm_select_byte[ALG_PROX_BIT] ||
        phi_q.algorithm_select_byte[ALG_DIST_BIT:ALG_PROX_BIT] == 2'b00);
      run_q.second_force <= go_dist;
    end
  end

  // ---------------------------------------------------------------
  // measurement sequencer
  // ---------------------------------------------------------------
  assign fn_first = phi_q.pin_function_byte[3:0];
  assign fn_second = phi_q.pin_function_byte[7:4];
  assign pulse_first = fn_first == PIN_PULSE && run_q.pulse_code != 8'h00;
  assign pulse_second = run_q.pulse_code != 8'h00 &&
                        (fn_second == PIN_PULSE || run_q.second_force);
  assign lead_cyc = (run_q.pulse_code > 8'h01) ?
                    32'(run_q.pulse_code - 8'h01) * LEAD_STEP_CYCLES : '0;
  assign lead_need = (pulse_first || pulse_second) ? lead_cyc : '0;
  assign period_cyc = 32'(run_q.period_ms) * PERIOD_CYCLES;
  assign inhibit = (fn_first == PIN_IN_LOW && !aux_pin_first_i) ||
                   (fn_first == PIN_IN_HIGH && aux_pin_first_i) ||
                   (fn_second == PIN_IN_LOW && !aux_pin_second_i) ||
                   (fn_second == PIN_IN_HIGH && aux_pin_second_i);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: state_d = ST_IDLE;
      ST_ARM: begin
        if (!inhibit) begin
          state_d = (lead_need != '0) ? ST_LEAD : ST_EMIT;
        end
      end
      ST_LEAD: begin
        if (cnt_q >= lead_need - 32'd1) begin
          state_d = ST_EMIT;
        end
      end
      ST_EMIT: begin
        if (cnt_q >= RANGE_CYCLES - 1) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE, ST_WAIT: begin
        if (run_q.period_ms == 8'h00) begin
          state_d = ST_IDLE;
        end else if (per_q >= period_cyc - 32'd1) begin
          state_d = ST_ARM;
        end else begin
          state_d = ST_WAIT;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (inhibit && (state_q == ST_LEAD || state_q == ST_EMIT)) begin
      state_d = ST_ARM;
    end
    if (stop) begin
      state_d = ST_IDLE;
    end
    if (go_comb || go_dist) begin
      state_d = ST_ARM;
    end
  end

  assign active_d = state_d == ST_LEAD || state_d == ST_EMIT;
  assign restart = active_d && !active_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      active_q <= 1'b0;
      cnt_q <= '0;
      per_q <= '0;
    end else begin
      state_q <= state_d;
      active_q <= active_d;
      cnt_q <= (state_d != state_q) ? '0 : cnt_q + 32'd1;
      if (restart) begin
        per_q <= 32'd0;
      end else if (per_q != 32'hFFFF_FFFF) begin
        per_q <= per_q + 32'd1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tid_q <= '0;
    end else if (state_q == ST_DONE) begin
      tid_q <= tid_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // emitter and aux pins
  // ---------------------------------------------------------------
  assign frame_d = active_d && (pulse_first || pulse_second);
  assign drv_first = pin_drive(fn_first, pulse_first, frame_d);
  assign drv_second = pin_drive(fn_second, pulse_second, frame_d);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emitter_on_q <= 1'b0;
      frame_q <= 1'b0;
      first_oe_q <= 1'b0;
      first_o_q <= 1'b0;
      second_oe_q <= 1'b0;
      second_o_q <= 1'b0;
    end else begin
      emitter_on_q <= state_d == ST_EMIT;
      frame_q <= frame_d;
      {first_oe_q, first_o_q} <= drv_first;
      {second_oe_q, second_o_q} <= drv_second;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, clear and enable
  // ---------------------------------------------------------------
  always_comb begin
    sts_set = '0;
    sts_set[STS_DONE] = state_q == ST_DONE;
    sts_set[STS_PARAM] = go_comb && (plo_q.param_byte_zero != RSV_FILL ||
      plo_q.param_byte_one != RSV_FILL || plo_q.param_byte_three != RSV_ZERO);
    sts_clr = (do_wr && is_reg(aw_addr_q, OFF_IRQ_CLEAR) && w_strb_q[0]) ?
              w_data_q[STS_W-1:0] : '0;
    sts_d = (sts_q & ~sts_clr) | sts_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_q <= '0;
      irq_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      irq_q <= |(sts_d & en_q);
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  assign ar_addr = s_axi_araddr;

  always_comb begin
    rd_mux = '0;
    if (is_reg(ar_addr, OFF_PARAM_LO)) begin
      rd_mux = plo_q;
    end else if (is_reg(ar_addr, OFF_PARAM_HI)) begin
      rd_mux = {8'h00, phi_q};
    end else if (is_reg(ar_addr, OFF_COMMAND)) begin
      rd_mux = {24'h00_0000, cmd_q};
    end else if (is_reg(ar_addr, OFF_IRQ_STATUS)) begin
      rd_mux[STS_W-1:0] = sts_q;
    end else if (is_reg(ar_addr, OFF_IRQ_ENABLE)) begin
      rd_mux[STS_W-1:0] = en_q;
    end else if (is_reg(ar_addr, OFF_STATE)) begin
      rd_mux[7:0] = tid_q;
      rd_mux[STATE_BUSY_BIT] = state_q != ST_IDLE;
      rd_mux[STATE_PROX_BIT] = run_q.prox;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= is_mapped(ar_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign emitter_on = emitter_on_q;
  assign irq = irq_q;
  assign aux_pin_first_o = first_o_q;
  assign aux_pin_first_oe = first_oe_q;
  assign aux_pin_second_o = second_o_q;
  assign aux_pin_second_oe = second_oe_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !frame_q || emitter_on_q) begin
      frame_cnt_q <= '0;
    end else begin
      frame_cnt_q <= frame_cnt_q + 32'd1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_lead_length: assert property ($rose(emitter_on_q) && frame_q |-> frame_cnt_q == lead_need)
    else $error("framing lead time wrong");
  a_fall_together: assert property ($fell(emitter_on_q) |-> !frame_q)
    else $error("frame did not fall with emitter");
  a_pulse_pin_gate: assert property (aux_pin_first_o && fn_first == PIN_PULSE |-> frame_q)
    else $error("pulse pin high outside frame");
  a_single_shot: assert property (state_q == ST_DONE && run_q.period_ms == 8'h00 |=> state_q == ST_IDLE)
    else $error("single measurement repeated");
  a_back_to_back: assert property (state_q == ST_DONE && run_q.period_ms != 8'h00 && per_q >= period_cyc
    && !go_comb && !go_dist && !stop |=> state_q == ST_ARM)
    else $error("late measurement not restarted");
  a_irq_enabled: assert property (state_q == ST_DONE && en_q[STS_DONE] |=> irq_q)
    else $error("done interrupt missing");
  a_irq_masked: assert property (!(|(sts_q & en_q)) && $past(!(|(sts_q & en_q))) |-> !irq_q)
    else $error("interrupt without enabled status");
  a_tid_step: assert property (state_q == ST_DONE |=> tid_q == $past(tid_q) + 8'h01)
    else $error("transaction id not advanced");
  a_dist_no_prox: assert property (go_dist |=> !run_q.prox ##1 state_q == ST_ARM || !$stable(state_q))
    else $error("distance-only run used proximity");
  a_prox_select: assert property (go_comb && phi_q.algorithm_select_byte[ALG_PROX_BIT] |=> run_q.prox)
    else $error("proximity not enabled");

  c_periodic: cover property (state_q == ST_WAIT ##[1:1000] state_q == ST_ARM);
  c_lead_frame: cover property ($rose(emitter_on_q) && frame_cnt_q != '0);
  c_irq: cover property ($rose(irq_q));
endmodule : rcp_top

`default_nettype wire

// ### verif/rcp_pin_model.sv
// pin partner: resolves a two-way auxiliary pin from the block's drive and enable
`timescale 1ns/1ps
`default_nettype none
module rcp_pin_model (
  input wire logic aclk,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_lvl
);
  logic float_q;
  // ---------------------------------------------------------------
  // released line keeps changing so stale values never look valid
  // ---------------------------------------------------------------
  initial float_q = 1'b0;
  always @(posedge aclk) begin
    float_q <= ~float_q;
  end
  assign pin_lvl = pin_oe ? pin_o : float_q;
endmodule : rcp_pin_model
`default_nettype wire

// ### verif/ranging_command_params_tb.sv
// testbench of the ranging command block
`timescale 1ns/1ps
`default_nettype none
module ranging_command_params_tb import rcp_pkg::*;;
  localparam int LS = 4;
  localparam int RC = 8;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic aux_pin_first_i, aux_pin_first_o, aux_pin_first_oe;
  logic aux_pin_second_i, aux_pin_second_o, aux_pin_second_oe, emitter_on, irq;
  int fail_count = 0, tests_run = 0, tid = 0, n = 0;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  always #2.5 aclk = ~aclk;
  rcp_top #(.LEAD_STEP_CYCLES(LS), .PERIOD_CYCLES(4), .RANGE_CYCLES(RC)) rcp_top_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .aux_pin_first_i, .aux_pin_first_o,
    .aux_pin_first_oe, .aux_pin_second_i, .aux_pin_second_o, .aux_pin_second_oe,
    .emitter_on, .irq);
  rcp_pin_model rcp_pin_model_i (.aclk(aclk), .pin_o(aux_pin_first_o),
    .pin_oe(aux_pin_first_oe), .pin_lvl(aux_pin_first_i));
  rcp_pin_model rcp_pin_model2_i (.aclk(aclk), .pin_o(aux_pin_second_o),
    .pin_oe(aux_pin_second_oe), .pin_lvl(aux_pin_second_i));
  // ---------------------------------------------------------------
  // compare, verdict, watchdog
  // ---------------------------------------------------------------
  task cmp(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    end_of_test();
  end
  // ---------------------------------------------------------------
  // response monitor: oldest note against each answer
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) cmp({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
    if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
  end
  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    exp_b.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task rd(input logic [7:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // ---------------------------------------------------------------
  // measurement observation
  // ---------------------------------------------------------------
  function automatic logic frame(input logic sel);
    return sel ? aux_pin_second_o : aux_pin_first_o;
  endfunction : frame
  task meas(input logic sel, input int lead, input logic fe);
    logic fr;
    n = 0;
    fr = 1'b0;
    while (!emitter_on && !frame(sel)) @(posedge aclk);
    while (!emitter_on) begin
      n++;
      @(posedge aclk);
    end
    cmp(34'(n), 34'(lead));
    while (emitter_on) begin
      fr = frame(sel);
      @(posedge aclk);
    end
    cmp({33'h0, fr}, {33'h0, fe});
    cmp({33'h0, frame(sel)}, 34'h0);
  endtask : meas
  task run(input logic [7:0] cmd, input logic [31:0] lo, input logic [31:0] hi,
           input logic sel, input int lead, input logic fe);
    wr(OFF_PARAM_LO, lo, RESP_OKAY);
    wr(OFF_PARAM_HI, hi, RESP_OKAY);
    wr(OFF_COMMAND, {24'h0, cmd}, RESP_OKAY);
    meas(sel, lead, fe);
    tid++;
    repeat (2) @(posedge aclk);
  endtask : run
  task rtr;
    n = 0;
    while (!emitter_on) @(posedge aclk);
    while (emitter_on) begin
      n++;
      @(posedge aclk);
    end
    while (!emitter_on) begin
      n++;
      @(posedge aclk);
    end
  endtask : rtr
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int c;
    void'($urandom(49));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    cmp({32'h0, aux_pin_first_oe, aux_pin_first_o}, 34'h2);
    rd(OFF_IRQ_STATUS, 34'h0);
    rd(OFF_IRQ_ENABLE, 34'h0);
    rd(OFF_STATE, 34'h0);
    rd(8'h30, {RESP_SLVERR, 32'h0});
    wr(8'h30, 32'h1, RESP_SLVERR);
    wr(OFF_IRQ_ENABLE, 32'h1, RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      c = (i < 5) ? i : 4 + $urandom_range(2);
      run(CMD_COMBINED, 32'h0000FFFF, {8'h0, 8'h01, 8'h33, 8'(c)}, 1'b0,
          (c >= 2) ? (c - 1) * LS : 0, c != 0);
      cmp({33'h0, irq}, 34'h1);
      rd(OFF_IRQ_STATUS, 34'h1);
      rd(OFF_STATE, 34'(tid) | 34'h200);
      wr(OFF_IRQ_CLEAR, 32'h3, RESP_OKAY);
      repeat (2) @(posedge aclk);
      cmp({33'h0, irq}, 34'h0);
    end
    wr(OFF_IRQ_ENABLE, 32'h0, RESP_OKAY);
    run(CMD_COMBINED, 32'h0100FFFF, {8'h0, 8'h01, 8'h33, 8'h02}, 1'b0, LS, 1'b1);
    cmp({33'h0, irq}, 34'h0);
    rd(OFF_IRQ_STATUS, 34'h3);
    wr(OFF_IRQ_ENABLE, 32'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp({33'h0, irq}, 34'h1);
    wr(OFF_IRQ_CLEAR, 32'h3, RESP_OKAY);
    run(CMD_DISTANCE, 32'h0000FFFF, {8'h0, 8'h01, PIN_FN_RST, 8'h02}, 1'b1, LS, 1'b1);
    rd(OFF_STATE, 34'(tid));
    wr(OFF_IRQ_CLEAR, 32'h3, RESP_OKAY);
    run(CMD_COMBINED, 32'h0001FFFF, {8'h0, 8'h01, 8'h33, 8'h01}, 1'b0, 0, 1'b1);
    rtr();
    cmp({33'h0, n > RC && n <= RC + 3}, 34'h1);
    wr(OFF_COMMAND, {24'h0, CMD_STOP}, RESP_OKAY);
    repeat (RC + 6) @(posedge aclk);
    run(CMD_COMBINED, 32'h0003FFFF, {8'h0, 8'h01, 8'h33, 8'h01}, 1'b0, 0, 1'b1);
    rtr();
    cmp({33'h0, n >= 12 && n <= 13}, 34'h1);
    wr(OFF_COMMAND, {24'h0, CMD_STOP}, RESP_OKAY);
    repeat (RC + 6) @(posedge aclk);
    repeat (30) @(posedge aclk);
    cmp({33'h0, emitter_on}, 34'h0);
    end_of_test();
  end
endmodule : ranging_command_params_tb
`default_nettype wire
